// ---- pkg/sadc_pkg.sv ----
package sadc_pkg;
   localparam int DATA_W = 16;
   localparam int SER_BITS = 16;
   localparam int CLK_PERIOD_NS = 100;
   // Least acquisition and conversion times, rounded up to whole clock cycles.
   localparam int ACQ_TIME_NS = 2000;
   localparam int ACQ_CYC = (ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CONV_TIME_NS = 8000;
   localparam int CONV_CYC = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Internal serial clock half period, rounded down but at least one cycle, so the clock is only slower when that floor applies.
   localparam int SCLK_HALF_NS = 200;
   localparam int SCLK_HALF_CYC = (SCLK_HALF_NS / CLK_PERIOD_NS < 1) ? 1 :
                                  SCLK_HALF_NS / CLK_PERIOD_NS;
   // Register port.
   localparam int REG_ADDR_W = 2;
   localparam logic [1:0] REG_STATUS = 2'h0;
   localparam logic [1:0] REG_MASK = 2'h1;
   localparam logic [1:0] REG_RESULT = 2'h2;
   localparam logic [1:0] REG_CONV_LEN = 2'h3;
   localparam int ST_DONE_BIT = 0;
   localparam int ST_RDERR_BIT = 1;
   localparam int ST_BUSY_BIT = 8;
   localparam int ST_PWRDN_BIT = 9;
   localparam logic [1:0] MASK_RST = 2'h0;
   localparam logic [15:0] CONV_LEN_RST = 16'(CONV_CYC);
   // Positions of the synchronised input vector.
   localparam int IN_SER = 0;
   localparam int IN_RD = 1;
   localparam int IN_CS = 2;
   localparam int IN_CNV = 3;
   localparam int IN_RST = 4;
   localparam int IN_PWRDN = 5;
   localparam int IN_DATA = 6;
   localparam int IN_W = IN_DATA + DATA_W;
   // Idle levels of the synchronised inputs; the active-low ones rest high.
   localparam logic [IN_W-1:0] IN_IDLE = IN_W'((32'h1 << IN_CS) | (32'h1 << IN_RD) |
                                                (32'h1 << IN_CNV));
   // Shared data pins used by the serial port.
   localparam int PIN_CLKSRC = 4;
   localparam int PIN_SYNCINV = 5;
   localparam int PIN_CLKINV = 6;
   localparam int PIN_RDMODE = 7;
   localparam int PIN_SER_OUT = 8;
   localparam int PIN_SCLK = 9;
   localparam int PIN_SYNC = 10;
   localparam int PIN_RDERR = 11;
   localparam int PIN_SER_LO = 4;
   localparam int PIN_SER_HI = 11;
endpackage : sadc_pkg

// ---- rtl/sadc_sync.sv ----
`timescale 1ns/1ps
module sadc_sync #(
   parameter int W = 1,
   // Idle level of each pin, so that leaving reset shows no false edge.
   parameter logic [W-1:0] RST_VAL = '0
) (
   // Clock and reset.
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // Asynchronous inputs.
   input wire logic [W-1:0] pin_i,
   // Synchronised level and edges.
   output logic [W-1:0] level_o,
   output logic [W-1:0] rise_o,
   output logic [W-1:0] fall_o
);
   typedef struct packed {
      logic [W-1:0] meta_reg;
      logic [W-1:0] lvl_reg;
      logic [W-1:0] old_reg;
   } sadc_sync_t;

   sadc_sync_t s;
   sadc_sync_t n;

   // Only the second stage and later are looked at, the first may be metastable.
   always_comb
   begin
      n.meta_reg = pin_i;
      n.lvl_reg = s.meta_reg;
      n.old_reg = s.lvl_reg;
   end

   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
         s <= {RST_VAL, RST_VAL, RST_VAL};
      else
         s <= n;
   end

   assign level_o = s.lvl_reg;
   assign rise_o = s.lvl_reg & ~s.old_reg;
   assign fall_o = ~s.lvl_reg & s.old_reg;
endmodule : sadc_sync

// ---- rtl/sadc_top.sv ----
`timescale 1ns/1ps
module sadc_top (
   // Clock and reset.
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // Converter control pins.
   input wire logic convert_start_n_i,
   input wire logic reset_pin_i,
   input wire logic power_down_request_i,
   input wire logic serial_parallel_select_i,
   input wire logic cs_n_i,
   input wire logic rd_n_i,
   // Result from the analog core.
   input wire logic [15:0] adc_code_i,
   // Shared data pins.
   input wire logic [15:0] data_i,
   output logic [15:0] data_o,
   output logic [15:0] data_oe_n_o,
   output logic busy_o,
   // Register port.
   input wire logic [1:0] reg_addr_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic reg_we_i,
   input wire logic reg_re_i,
   output logic [15:0] reg_rdata_o,
   output logic irq_o
);
   typedef enum logic [1:0] {ST_ACQ, ST_WAIT, ST_CONV, ST_PWRDN} sadc_st_t;

   typedef struct packed {
      sadc_st_t st;
      logic [15:0] cnt;
      logic [15:0] conv_len_reg;
      logic [15:0] result_reg;
      logic [15:0] shift_reg;
      logic ready_reg;
      logic frame_reg;
      logic [4:0] bit_cnt;
      logic [3:0] div_cnt;
      logic sclk_reg;
      logic rderr_reg;
      logic busy_reg;
      logic [1:0] status_reg;
      logic [1:0] mask_reg;
      logic [15:0] rdata_reg;
      logic [15:0] data_reg;
      logic [15:0] oe_n_reg;
      logic irq_reg;
   } sadc_state_t;

   sadc_state_t s;
   sadc_state_t n;

   logic [sadc_pkg::IN_W-1:0] pins_raw;
   logic [sadc_pkg::IN_W-1:0] lvl;
   logic [sadc_pkg::IN_W-1:0] rise;
   logic [sadc_pkg::IN_W-1:0] fall;
   logic ser;
   logic bus_en;
   logic ext;
   logic clk_inv;
   logic sync_inv;
   logic rd_mode;
   logic pin_rst;
   logic pwr_dn;
   logic cnv_fall;
   logic sclk_rise;
   logic sclk_fall;
   logic upd_edge;
   logic val_edge;
   logic acq_end;
   logic conv_end;
   logic start_conv;
   logic [1:0] events;
   logic [1:0] w1c;

   assign pins_raw = {data_i, power_down_request_i, reset_pin_i, convert_start_n_i,
                      cs_n_i, rd_n_i, serial_parallel_select_i};

   sadc_sync #(
      .W(sadc_pkg::IN_W),
      .RST_VAL(sadc_pkg::IN_IDLE)
   ) u_sync (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .pin_i(pins_raw),
      .level_o(lvl),
      .rise_o(rise),
      .fall_o(fall)
   );

   assign ser = lvl[sadc_pkg::IN_SER];
   assign bus_en = !(lvl[sadc_pkg::IN_CS] | lvl[sadc_pkg::IN_RD]);
   assign ext = ser & lvl[sadc_pkg::IN_DATA + sadc_pkg::PIN_CLKSRC];
   assign sync_inv = lvl[sadc_pkg::IN_DATA + sadc_pkg::PIN_SYNCINV];
   assign clk_inv = lvl[sadc_pkg::IN_DATA + sadc_pkg::PIN_CLKINV];
   assign rd_mode = lvl[sadc_pkg::IN_DATA + sadc_pkg::PIN_RDMODE];
   assign pin_rst = lvl[sadc_pkg::IN_RST];
   assign pwr_dn = lvl[sadc_pkg::IN_PWRDN];
   assign cnv_fall = fall[sadc_pkg::IN_CNV];
   assign sclk_rise = rise[sadc_pkg::IN_DATA + sadc_pkg::PIN_SCLK];
   assign sclk_fall = fall[sadc_pkg::IN_DATA + sadc_pkg::PIN_SCLK];
   assign upd_edge = clk_inv ? sclk_fall : sclk_rise;
   assign val_edge = clk_inv ? sclk_rise : sclk_fall;
   assign acq_end = (s.st == ST_ACQ) && (s.cnt == 16'(sadc_pkg::ACQ_CYC - 1));
   assign conv_end = (s.st == ST_CONV) &&
                     (({1'b0, s.cnt} + 17'h00001) >= {1'b0, s.conv_len_reg});
   // A start is only taken while no power down is pending.
   assign start_conv = !pin_rst && !pwr_dn &&
                       ((acq_end && !lvl[sadc_pkg::IN_CNV]) ||
                        ((s.st == ST_WAIT) && cnv_fall));
   assign w1c = (reg_we_i && (reg_addr_i == sadc_pkg::REG_STATUS)) ? reg_wdata_i[1:0] : 2'h0;

   always_comb
   begin
      n = s;
      n.rderr_reg = 1'b0;
      events = 2'h0;

      // Serial engine.
      if (!ser)
      begin
         n.frame_reg = 1'b0;
         n.sclk_reg = 1'b0;
      end
      else if (!ext)
      begin
         if (!s.frame_reg)
         begin
            n.sclk_reg = 1'b0;
            if (s.ready_reg && bus_en &&
                (rd_mode ? (s.st == ST_CONV) : (s.st != ST_CONV)))
            begin
               n.frame_reg = 1'b1;
               n.shift_reg = s.result_reg;
               n.bit_cnt = 5'h00;
               n.div_cnt = 4'h0;
               n.ready_reg = 1'b0;
            end
         end
         else if (s.div_cnt == 4'(sadc_pkg::SCLK_HALF_CYC - 1))
         begin
            n.div_cnt = 4'h0;
            n.sclk_reg = !s.sclk_reg;
            // Data moves on the falling edge so it is stable at the rising edge.
            if (s.sclk_reg)
            begin
               if (s.bit_cnt == 5'(sadc_pkg::SER_BITS - 1))
                  n.frame_reg = 1'b0;
               else
               begin
                  n.shift_reg = {s.shift_reg[14:0], 1'b0};
                  n.bit_cnt = s.bit_cnt + 5'h01;
               end
            end
         end
         else
            n.div_cnt = s.div_cnt + 4'h1;
      end
      else
      begin
         n.sclk_reg = 1'b0;
         if (!s.frame_reg)
         begin
            if (s.ready_reg && bus_en)
            begin
               n.frame_reg = 1'b1;
               n.shift_reg = s.result_reg;
               n.bit_cnt = 5'h00;
               n.ready_reg = 1'b0;
            end
         end
         else if (val_edge)
         begin
            if (s.bit_cnt == 5'(sadc_pkg::SER_BITS - 1))
               n.frame_reg = 1'b0;
            else
               n.bit_cnt = s.bit_cnt + 5'h01;
         end
         else if (upd_edge && (s.bit_cnt != 5'h00))
            // The daisy-chain input fills the word from below.
            n.shift_reg = {s.shift_reg[14:0],
                           lvl[sadc_pkg::IN_DATA + sadc_pkg::PIN_RDMODE]};
      end

      // Conversion sequencer.
      case (s.st)
         ST_ACQ:
         begin
            n.cnt = s.cnt + 16'h0001;
            if (acq_end)
            begin
               n.cnt = 16'h0000;
               n.st = pwr_dn ? ST_PWRDN : ST_WAIT;
            end
         end
         ST_WAIT:
            if (pwr_dn)
               n.st = ST_PWRDN;
         ST_CONV:
         begin
            n.cnt = s.cnt + 16'h0001;
            if (conv_end)
            begin
               n.cnt = 16'h0000;
               n.busy_reg = 1'b0;
               n.result_reg = adc_code_i;
               n.ready_reg = 1'b1;
               events[sadc_pkg::ST_DONE_BIT] = 1'b1;
               // A read still in flight is abandoned; the new word replaces it.
               if (s.frame_reg && !n.frame_reg)
                  n.frame_reg = 1'b0;
               else if (s.frame_reg)
               begin
                  n.frame_reg = 1'b0;
                  if (ext)
                  begin
                     n.rderr_reg = 1'b1;
                     events[sadc_pkg::ST_RDERR_BIT] = 1'b1;
                  end
               end
               n.st = pwr_dn ? ST_PWRDN : ST_ACQ;
            end
         end
         ST_PWRDN:
            if (!pwr_dn)
            begin
               n.st = ST_ACQ;
               n.cnt = 16'h0000;
            end
         default:
         begin
            n.st = ST_ACQ;
            n.cnt = 16'h0000;
         end
      endcase

      if (start_conv)
      begin
         n.st = ST_CONV;
         n.cnt = 16'h0000;
         n.busy_reg = 1'b1;
      end

      if (pin_rst)
      begin
         n.st = ST_ACQ;
         n.cnt = 16'h0000;
         n.busy_reg = 1'b0;
         n.ready_reg = 1'b0;
         n.frame_reg = 1'b0;
         n.sclk_reg = 1'b0;
         n.rderr_reg = 1'b0;
         events = 2'h0;
      end

      // Register port; a new event wins over a clear in the same cycle.
      n.status_reg = (s.status_reg & ~w1c) | events;
      if (reg_we_i && (reg_addr_i == sadc_pkg::REG_MASK))
         n.mask_reg = reg_wdata_i[1:0];
      if (reg_we_i && (reg_addr_i == sadc_pkg::REG_CONV_LEN))
         n.conv_len_reg = reg_wdata_i;
      n.rdata_reg = 16'h0000;
      if (reg_re_i)
         case (reg_addr_i)
            sadc_pkg::REG_STATUS:
            begin
               n.rdata_reg[1:0] = s.status_reg;
               n.rdata_reg[sadc_pkg::ST_BUSY_BIT] = s.busy_reg;
               n.rdata_reg[sadc_pkg::ST_PWRDN_BIT] = (s.st == ST_PWRDN);
            end
            sadc_pkg::REG_MASK:
               n.rdata_reg[1:0] = s.mask_reg;
            sadc_pkg::REG_RESULT:
               n.rdata_reg = s.result_reg;
            default:
               n.rdata_reg = s.conv_len_reg;
         endcase
      n.irq_reg = |(n.status_reg & n.mask_reg);

      // Pin drive, built from the next state so no extra lag is added.
      for (int k = 0; k < sadc_pkg::DATA_W; k++)
      begin
         n.data_reg[k] = n.result_reg[k];
         n.oe_n_reg[k] = !bus_en;
         if (ser && (k >= sadc_pkg::PIN_SER_LO) && (k <= sadc_pkg::PIN_SER_HI))
         begin
            n.data_reg[k] = 1'b0;
            n.oe_n_reg[k] = 1'b1;
         end
      end
      if (ser)
      begin
         n.data_reg[sadc_pkg::PIN_SER_OUT] = n.shift_reg[15] & n.frame_reg;
         n.oe_n_reg[sadc_pkg::PIN_SER_OUT] = !bus_en;
         n.data_reg[sadc_pkg::PIN_SCLK] = n.sclk_reg ^ clk_inv;
         n.oe_n_reg[sadc_pkg::PIN_SCLK] = ext;
         // With the host clock the sync pin just rests at its inactive level.
         n.data_reg[sadc_pkg::PIN_SYNC] = (n.frame_reg & !ext) ^ sync_inv;
         n.oe_n_reg[sadc_pkg::PIN_SYNC] = 1'b0;
         n.data_reg[sadc_pkg::PIN_RDERR] = n.rderr_reg;
         n.oe_n_reg[sadc_pkg::PIN_RDERR] = 1'b0;
      end
   end

   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
      begin
         s <= '0;
         s.conv_len_reg <= sadc_pkg::CONV_LEN_RST;
         s.mask_reg <= sadc_pkg::MASK_RST;
         s.oe_n_reg <= 16'hFFFF;
      end
      else
         s <= n;
   end

   assign data_o = s.data_reg;
   assign data_oe_n_o = s.oe_n_reg;
   assign busy_o = s.busy_reg;
   assign reg_rdata_o = s.rdata_reg;
   assign irq_o = s.irq_reg;

   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_n_i);

   sequence seq_wait_start;
      (s.st == ST_WAIT) && cnv_fall && !pin_rst && !pwr_dn;
   endsequence

   sequence seq_conv_done;
      conv_end && !pin_rst;
   endsequence

   a_start_on_edge: assert property (seq_wait_start |=> busy_o ##1 busy_o)
      else $error("Falling start edge did not begin a conversion.");

   a_start_at_once: assert property (
      acq_end && !lvl[sadc_pkg::IN_CNV] && !pin_rst && !pwr_dn |=> busy_o && (s.st == ST_CONV))
      else $error("Low start at acquisition end did not convert at once.");

   a_busy_till_latch: assert property (
      seq_conv_done |=> !busy_o && (s.result_reg == $past(adc_code_i)) && s.ready_reg)
      else $error("Busy fell without the result latched.");

   a_busy_no_early: assert property (
      busy_o && !conv_end && !pin_rst |=> busy_o)
      else $error("Busy fell before the conversion ended.");

   a_reset_abort: assert property (pin_rst |=> !busy_o && (s.st == ST_ACQ))
      else $error("Reset pin did not abort the conversion.");

   a_pwrdn_inhibit: assert property (
      pwr_dn && !busy_o && !pin_rst ##1 pwr_dn |-> !busy_o)
      else $error("Conversion started during power down.");

   a_rderr_pulse: assert property (
      seq_conv_done and (ext && s.frame_reg &&
                         !(val_edge && (s.bit_cnt == 5'(sadc_pkg::SER_BITS - 1))))
      |=> s.rderr_reg ##1 !s.rderr_reg)
      else $error("Incomplete read did not pulse the error flag once.");

   a_msb_first: assert property (
      $rose(s.frame_reg) |-> s.shift_reg == $past(s.result_reg))
      else $error("Serial word did not start from the latched result.");

   a_frame_length: assert property (
      $fell(s.frame_reg) && !$past(conv_end) && !$past(pin_rst) && $past(ser)
      |-> $past(s.bit_cnt) == 5'(sadc_pkg::SER_BITS - 1))
      else $error("Frame ended before sixteen bits were sent.");

   a_bus_enable: assert property (
      !$past(ser) && !ser |-> data_oe_n_o == {16{$past(!bus_en)}})
      else $error("Parallel bus enable does not follow chip select and read.");

   a_parallel_bits: assert property (
      $past(!ser) |-> data_o[11:9] == s.result_reg[11:9])
      else $error("Parallel bits 9 to 11 do not show the result.");
endmodule : sadc_top

// ---- tb/sadc_host.sv ----
`timescale 1ns/1ps
module sadc_host (
   // Clock and converter status.
   input wire logic mclk_i,
   input wire logic busy_i,
   input wire logic sdo_i,
   input wire logic clk_inv_i,
   // Host controls.
   output logic cnv_n_o,
   output logic cs_n_o,
   output logic rd_n_o,
   output logic sclk_o
);
   logic ph = 1'h0;

   // The serial clock rests at the idle level that the invert select implies.
   assign sclk_o = ph ^ clk_inv_i;

   initial
   begin
      cnv_n_o = 1'h1;
      cs_n_o = 1'h1;
      rd_n_o = 1'h1;
   end

   // Holding start low until busy rises also covers a request made during acquisition.
   task automatic start_conv();
      @(posedge mclk_i);
      cnv_n_o <= 1'h0;
      for (int i = 0; i < 60; i++)
      begin
         @(posedge mclk_i);
         if (busy_i === 1'h1)
            break;
      end
      cnv_n_o <= 1'h1;
   endtask : start_conv

   task automatic wait_ready();
      for (int i = 0; i < 1000 && busy_i !== 1'h0; i++)
         @(posedge mclk_i);
   endtask : wait_ready

   task automatic select(input logic cs_n, input logic rd_n);
      @(posedge mclk_i);
      cs_n_o <= cs_n;
      rd_n_o <= rd_n;
   endtask : select

   // The link clock is free of the system clock phase on purpose.
   task automatic ext_read(input int n, output logic [15:0] w);
      w = 16'h0000;
      #37;
      for (int i = 0; i < n; i++)
      begin
         ph = 1'h1;
         #400;
         ph = 1'h0;
         w = {w[14:0], sdo_i};
         #400;
      end
   endtask : ext_read
endmodule : sadc_host

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
module testbench;
   typedef struct packed {
      logic ser;
      logic ext;
      logic cinv;
      logic sinv;
      logic [15:0] code;
      logic [15:0] exp;
   } sadc_row_t;
   localparam int N_ROWS = 6;
   localparam sadc_row_t ROWS [N_ROWS] = '{
      '{1'h0, 1'h0, 1'h0, 1'h0, 16'hA5C3, 16'hA5C3},
      '{1'h0, 1'h0, 1'h0, 1'h0, 16'h0E01, 16'h0E01},
      '{1'h1, 1'h0, 1'h0, 1'h0, 16'h8001, 16'h8001},
      '{1'h1, 1'h0, 1'h1, 1'h1, 16'h7FFE, 16'h7FFE},
      '{1'h1, 1'h1, 1'h0, 1'h0, 16'hC35A, 16'hC35A},
      '{1'h1, 1'h1, 1'h1, 1'h0, 16'h5AC3, 16'h5AC3}};
   logic mclk = 1'h0;
   logic rst_n = 1'h0;
   logic reset_pin = 1'h0;
   logic pwr_dn = 1'h0;
   logic ser = 1'h0;
   logic [3:0] cfg = 4'h0;
   logic [15:0] code = 16'h0000;
   logic [1:0] reg_addr = 2'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_we = 1'h0;
   logic reg_re = 1'h0;
   logic cnv_n, cs_n, rd_n, sclk, busy, irq;
   logic [15:0] data_i, data_o, oe_n, reg_rdata, drv, w;
   int n_errors = 0;
   int total_checks = 0;
   int cycles = 0;
   int pulses;

   // Undriven pins other than the serial clock and the four config pins show the inverse of the last value so a stale level never matches.
   assign drv = {~data_o[15:10], sclk, ~data_o[8], cfg, ~data_o[3:0]};
   assign data_i = (data_o & ~oe_n) | (drv & oe_n);

   sadc_top sadc_top_inst (.mclk_i(mclk), .rst_n_i(rst_n), .convert_start_n_i(cnv_n),
      .reset_pin_i(reset_pin), .power_down_request_i(pwr_dn), .serial_parallel_select_i(ser),
      .cs_n_i(cs_n), .rd_n_i(rd_n), .adc_code_i(code), .data_i(data_i), .data_o(data_o),
      .data_oe_n_o(oe_n), .busy_o(busy), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
      .reg_we_i(reg_we), .reg_re_i(reg_re), .reg_rdata_o(reg_rdata), .irq_o(irq));
   sadc_host sadc_host_inst (.mclk_i(mclk), .busy_i(busy), .sdo_i(data_o[8]),
      .clk_inv_i(cfg[2]), .cnv_n_o(cnv_n), .cs_n_o(cs_n), .rd_n_o(rd_n), .sclk_o(sclk));

   always #50 mclk = ~mclk;

   always @(posedge mclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 30000)
      begin
         n_errors++;
         results();
      end
   end

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic reg_wr(input logic [1:0] a, input logic [15:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_we <= 1'h1;
      @(posedge mclk);
      reg_we <= 1'h0;
   endtask : reg_wr

   task automatic reg_rd(input logic [1:0] a, output logic [15:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_re <= 1'h1;
      @(posedge mclk);
      reg_re <= 1'h0;
      #1;
      d = reg_rdata;
   endtask : reg_rd

   task automatic int_read(input logic cinv, input logic sinv, output logic [15:0] v);
      logic prev;
      int n;
      v = 16'h0000;
      n = 0;
      prev = cinv;
      for (int i = 0; i < 100 && n < 16; i++)
      begin
         @(negedge mclk);
         if (prev !== data_o[9] && data_o[9] === ~cinv)
         begin
            v = {v[14:0], data_o[8]};
            n++;
            check("sync active", {15'h0, data_o[10]}, {15'h0, ~sinv});
         end
         prev = data_o[9];
      end
      repeat (12) @(negedge mclk);
      check("sync idle", {15'h0, data_o[10]}, {15'h0, sinv});
   endtask : int_read

   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : results

   initial
   begin
      repeat (8) @(posedge mclk);
      rst_n <= 1'h1;
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      check("busy idle", {15'h0, busy}, 16'h0000);
      check("oe idle", oe_n, 16'hFFFF);
      reg_rd(sadc_pkg::REG_CONV_LEN, w);
      check("conv len", w, sadc_pkg::CONV_LEN_RST);
      reg_rd(sadc_pkg::REG_MASK, w);
      check("mask", w, 16'h0000);
      // Interrupt: raised masked, unmasked, then cleared.
      code <= 16'h1234;
      sadc_host_inst.start_conv();
      sadc_host_inst.wait_ready();
      reg_rd(sadc_pkg::REG_STATUS, w);
      check("status done", w, 16'h0001);
      check("irq masked", {15'h0, irq}, 16'h0000);
      reg_wr(sadc_pkg::REG_MASK, 16'h0001);
      repeat (2) @(negedge mclk);
      check("irq on", {15'h0, irq}, 16'h0001);
      reg_wr(sadc_pkg::REG_STATUS, 16'h0001);
      repeat (2) @(negedge mclk);
      check("irq clear", {15'h0, irq}, 16'h0000);
      reg_wr(sadc_pkg::REG_MASK, 16'h0000);
      $display("interrupt test done");
      for (int r = 0; r < N_ROWS; r++)
      begin
         @(posedge mclk);
         ser <= ROWS[r].ser;
         cfg <= {1'h0, ROWS[r].cinv, ROWS[r].sinv, ROWS[r].ext};
         code <= ROWS[r].code;
         sadc_host_inst.start_conv();
         sadc_host_inst.wait_ready();
         check("busy done", {15'h0, busy}, 16'h0000);
         sadc_host_inst.select(1'h0, 1'h0);
         if (!ROWS[r].ser)
         begin
            repeat (5) @(negedge mclk);
            check("par data", data_o, ROWS[r].exp);
            check("par oe", oe_n, 16'h0000);
         end
         else
         begin
            // Chip select and read need two synchroniser stages and a register.
            repeat (4) @(negedge mclk);
            check("sclk dir", {15'h0, oe_n[9]}, {15'h0, ROWS[r].ext});
            check("high oe", oe_n & 16'hF000, 16'h0000);
            if (ROWS[r].ext)
               sadc_host_inst.ext_read(16, w);
            else
               int_read(ROWS[r].cinv, ROWS[r].sinv, w);
            check("ser word", w, ROWS[r].exp);
         end
         sadc_host_inst.select(1'h1, 1'h1);
         reg_rd(sadc_pkg::REG_RESULT, w);
         check("result", w, ROWS[r].code);
         $display("row %0d done", r);
      end
      // Read mode high: the last word leaves during the following conversion.
      @(posedge mclk);
      cfg <= 4'h8;
      code <= 16'h3C96;
      sadc_host_inst.start_conv();
      sadc_host_inst.wait_ready();
      sadc_host_inst.select(1'h0, 1'h0);
      repeat (5) @(negedge mclk);
      check("no early frame", {15'h0, data_o[10]}, 16'h0000);
      sadc_host_inst.start_conv();
      int_read(1'h0, 1'h0, w);
      check("ser during conv", w, 16'h3C96);
      sadc_host_inst.wait_ready();
      sadc_host_inst.select(1'h1, 1'h1);
      $display("read mode test done");
      // Output enable needs both chip select and read low.
      ser <= 1'h0;
      for (int k = 0; k < 4; k++)
      begin
         sadc_host_inst.select(k[1], k[0]);
         repeat (5) @(negedge mclk);
         check("oe gate", oe_n, (k == 0) ? 16'h0000 : 16'hFFFF);
      end
      sadc_host_inst.select(1'h1, 1'h1);
      $display("bus gate test done");
      // A slave read left unfinished when the next conversion ends.
      ser <= 1'h1;
      cfg <= 4'h1;
      sadc_host_inst.start_conv();
      sadc_host_inst.wait_ready();
      sadc_host_inst.select(1'h0, 1'h0);
      sadc_host_inst.ext_read(4, w);
      sadc_host_inst.start_conv();
      pulses = 0;
      for (int i = 0; i < 150; i++)
      begin
         @(negedge mclk);
         if (data_o[11] === 1'h1)
            pulses++;
      end
      check("err pulses", 16'(pulses), 16'h0001);
      reg_rd(sadc_pkg::REG_STATUS, w);
      check("err status", w & 16'h0002, 16'h0002);
      sadc_host_inst.select(1'h1, 1'h1);
      reg_wr(sadc_pkg::REG_STATUS, 16'h0003);
      $display("read error test done");
      // Reset pin in mid conversion.
      sadc_host_inst.start_conv();
      repeat (10) @(posedge mclk);
      reset_pin <= 1'h1;
      repeat (5) @(negedge mclk);
      check("busy abort", {15'h0, busy}, 16'h0000);
      @(posedge mclk);
      reset_pin <= 1'h0;
      $display("reset pin test done");
      // Power down lets the running conversion end, then blocks.
      sadc_host_inst.start_conv();
      @(posedge mclk);
      pwr_dn <= 1'h1;
      sadc_host_inst.wait_ready();
      repeat (3) @(posedge mclk);
      reg_rd(sadc_pkg::REG_STATUS, w);
      check("power down status", w, 16'h0201);
      sadc_host_inst.start_conv();
      @(negedge mclk);
      check("power down blocks", {15'h0, busy}, 16'h0000);
      @(posedge mclk);
      pwr_dn <= 1'h0;
      $display("power down test done");
      results();
   end
endmodule : testbench
